/* File: src/fpr_pkg.sv */
// Constants, pin bundle and state encoding for the fuse PROM programmer
package fpr_pkg;

	// Array shape of the target part and the retry limit per bit
	localparam int ADDR_W = 9;
	localparam int DATA_W = 8;
	localparam int WORDS = 512;
	localparam int MAX_TRIES = 8;

	// Clock and timing, each time in its own unit
	localparam int CLK_MHZ = 40;
	localparam int T_PULSE_MS = 100;
	localparam int T_SETTLE_US = 1000;
	localparam int T_AVEL_NS = 500;
	localparam int T_EHEL_NS = 500;
	localparam int T_ELQV_NS = 500;
	localparam int T_EDGE_US = 10;
	localparam int PULSE_CYC = T_PULSE_MS * 1000 * CLK_MHZ;
	localparam int SETTLE_CYC = T_SETTLE_US * CLK_MHZ;
	localparam int AVEL_CYC = (T_AVEL_NS * CLK_MHZ + 999) / 1000;
	localparam int EHEL_CYC = (T_EHEL_NS * CLK_MHZ + 999) / 1000;
	localparam int ELQV_CYC = (T_ELQV_NS * CLK_MHZ + 999) / 1000;
	localparam int EDGE_CYC = T_EDGE_US * CLK_MHZ;
	localparam int READ_CYC = ELQV_CYC + EDGE_CYC;
	localparam int TMR_W = 24;

	// Supply level selector for the external regulator
	typedef enum logic [1:0] {
		VCC_OFF = 2'h0,
		VCC_LOW = 2'h1,
		VCC_HIGH = 2'h2,
		VCC_PROG = 2'h3
	} fpr_vcc_t;

	// Gray coded along the program and verify path
	typedef enum logic [3:0] {
		S_IDLE = 4'h0,
		S_PWRUP = 4'h1,
		S_ADDR = 4'h3,
		S_LATCH = 4'h2,
		S_FWE_LO = 4'h6,
		S_VPROG = 4'h7,
		S_FWE_HI = 4'h5,
		S_PULSE = 4'h4,
		S_RELEASE = 4'hc,
		S_VDOWN = 4'hd,
		S_VADDR = 4'hf,
		S_VLATCH = 4'he,
		S_VREAD = 4'ha,
		S_VLOW = 4'hb,
		S_PWRDN = 4'h9,
		S_DONE = 4'h8
	} fpr_state_t;

	// Everything that goes to the socket
	typedef struct packed {
		fpr_vcc_t vcc;
		logic [ADDR_W-1:0] addr_in;
		logic chip_en_n;
		logic oe_third;
		logic [1:0] oe_others;
		logic fwe_logic;
		logic fwe_hv;
		logic [DATA_W-1:0] q_out;
		logic [DATA_W-1:0] q_oe;
	} fpr_pins_t;

	// Outcome of one job
	typedef struct packed {
		logic done;
		logic pass;
		logic fail_prog;
		logic fail_low;
	} fpr_result_t;

endpackage : fpr_pkg

/* File: src/fpr_prog_ctrl.sv */
// Programmer that burns and verifies one PROM word through the socket pins
`timescale 1ns/1ps
`default_nettype none

module fpr_prog_ctrl
	import fpr_pkg::*;
#(
	parameter int PULSE_CYC_P = fpr_pkg::PULSE_CYC,
	parameter int SETTLE_CYC_P = fpr_pkg::SETTLE_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Job request
	input wire logic start,
	input wire logic [fpr_pkg::ADDR_W-1:0] req_addr,
	input wire logic [fpr_pkg::DATA_W-1:0] req_data,
	// Job status
	output logic busy,
	output fpr_pkg::fpr_result_t res,
	// Socket
	input wire logic [fpr_pkg::DATA_W-1:0] q_in,
	output fpr_pkg::fpr_pins_t pins
);
	import fpr_pkg::*;

	fpr_state_t state;
	fpr_state_t next_state;
	logic [TMR_W-1:0] tmr;
	logic [ADDR_W-1:0] job_addr;
	logic [DATA_W-1:0] job_data;
	logic [DATA_W-1:0] pending;
	logic [2:0] tries;
	logic final_pass;
	logic [DATA_W-1:0] q_s1;
	logic [DATA_W-1:0] q_s2;
	logic [DATA_W-1:0] q_s3;
	logic [DATA_W-1:0] q_val;
	fpr_pins_t next_pins;

	function automatic logic [DATA_W-1:0] bit_mask(input logic [2:0] idx);
		bit_mask = DATA_W'(1) << idx;
	endfunction : bit_mask

	function automatic logic [2:0] lowest_set(input logic [DATA_W-1:0] m);
		lowest_set = 3'h0;
		for (int i = DATA_W - 1; i >= 0; i--) begin
			if (m[i]) begin
				lowest_set = 3'(i);
			end
		end
	endfunction : lowest_set

	function automatic logic [TMR_W-1:0] wait_of(input fpr_state_t s);
		case (s)
			S_PWRUP, S_VPROG, S_VDOWN, S_VLOW, S_DONE: wait_of = TMR_W'(SETTLE_CYC_P);
			S_ADDR, S_VADDR: wait_of = TMR_W'(AVEL_CYC);
			S_LATCH, S_VLATCH: wait_of = TMR_W'(EHEL_CYC);
			S_FWE_LO, S_FWE_HI, S_RELEASE, S_PWRDN: wait_of = TMR_W'(EDGE_CYC);
			S_PULSE: wait_of = TMR_W'(PULSE_CYC_P);
			S_VREAD: wait_of = TMR_W'(READ_CYC);
			default: wait_of = TMR_W'(1);
		endcase
	endfunction : wait_of

	// Decoding
	wire tz = (tmr == '0);
	wire [2:0] cur = lowest_set(pending);
	wire [DATA_W-1:0] cur_mask = bit_mask(cur);
	wire [DATA_W-1:0] pend_after = pending & ~cur_mask;
	wire bit_ok = q_val[cur];
	wire last_try = (tries == 3'(MAX_TRIES - 1));
	wire word_ok = (q_val == job_data);
	wire read_end = (state == S_VREAD) && tz;
	wire in_seq = !(state inside {S_IDLE, S_PWRUP, S_PWRDN, S_DONE});
	wire fwe_lo_on = state inside {S_FWE_LO, S_VPROG, S_FWE_HI, S_PULSE, S_RELEASE, S_VDOWN};
	wire fwe_hi_on = state inside {S_FWE_HI, S_PULSE};
	wire vcc_prog_on = state inside {S_VPROG, S_FWE_HI, S_PULSE, S_RELEASE};
	wire strobe_high = state inside {S_ADDR, S_VADDR, S_VLOW};
	wire [TMR_W-1:0] tmr_load = wait_of(next_state) - 1'b1;
	wire [DATA_W-1:0] q_agree = ~(q_s2 ^ q_s3);

	always_comb begin
		next_state = state;
		case (state)
			S_IDLE: if (start) next_state = S_PWRUP;
			S_PWRUP: if (tz) next_state = (|pending) ? S_ADDR : S_VLOW;
			S_ADDR: if (tz) next_state = S_LATCH;
			S_LATCH: if (tz) next_state = S_FWE_LO;
			S_FWE_LO: if (tz) next_state = S_VPROG;
			S_VPROG: if (tz) next_state = S_FWE_HI;
			S_FWE_HI: if (tz) next_state = S_PULSE;
			S_PULSE: if (tz) next_state = S_RELEASE;
			S_RELEASE: if (tz) next_state = S_VDOWN;
			S_VDOWN: if (tz) next_state = S_VADDR;
			S_VADDR: if (tz) next_state = S_VLATCH;
			S_VLATCH: if (tz) next_state = S_VREAD;
			S_VREAD: begin
				if (tz) begin
					if (final_pass) begin
						next_state = S_PWRDN;
					end else if (bit_ok) begin
						next_state = (|pend_after) ? S_ADDR : S_VLOW;
					end else begin
						next_state = last_try ? S_PWRDN : S_ADDR;
					end
				end
			end
			S_VLOW: if (tz) next_state = S_VADDR;
			S_PWRDN: if (tz) next_state = S_DONE;
			S_DONE: if (tz) next_state = S_IDLE;
			default: next_state = S_IDLE;
		endcase
	end

	// Pin levels follow the state; registered below so the socket sees no glitches
	assign next_pins.vcc = (state inside {S_IDLE, S_DONE}) ? VCC_OFF :
		vcc_prog_on ? VCC_PROG :
		(final_pass || state == S_VLOW) ? VCC_LOW : VCC_HIGH;
	assign next_pins.addr_in = in_seq ? job_addr : '0;
	assign next_pins.chip_en_n = strobe_high;
	assign next_pins.oe_third = (state == S_VREAD);
	assign next_pins.oe_others = in_seq ? 2'h3 : 2'h0;
	assign next_pins.fwe_logic = fwe_lo_on;
	assign next_pins.fwe_hv = fwe_hi_on;
	assign next_pins.q_out = '0;
	assign next_pins.q_oe = (state == S_PULSE) ? cur_mask : '0;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= S_IDLE;
			tmr <= '0;
		end else begin
			state <= next_state;
			tmr <= (next_state != state) ? tmr_load : (tz ? tmr : tmr - 1'b1);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			job_addr <= '0;
			job_data <= '0;
		end else if (state == S_IDLE && start) begin
			job_addr <= req_addr;
			job_data <= req_data;
		end
	end

	// Bit bookkeeping; a bit leaves the list only once it reads back as 1
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pending <= '0;
			tries <= 3'h0;
			final_pass <= 1'b0;
		end else if (state == S_IDLE && start) begin
			pending <= req_data;
			tries <= 3'h0;
			final_pass <= 1'b0;
		end else if (state == S_VLOW) begin
			final_pass <= 1'b1;
		end else if (read_end && !final_pass) begin
			pending <= bit_ok ? pend_after : pending;
			tries <= bit_ok ? 3'h0 : tries + 3'h1;
		end
	end

	// Data pins come from the socket: three stages, accepted when the last two agree
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			q_s1 <= '0;
			q_s2 <= '0;
			q_s3 <= '0;
			q_val <= '0;
		end else begin
			q_s1 <= q_in;
			q_s2 <= q_s1;
			q_s3 <= q_s2;
			q_val <= (q_s3 & q_agree) | (q_val & ~q_agree);
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pins <= '0;
			busy <= 1'b0;
		end else begin
			pins <= next_pins;
			busy <= (state != S_IDLE);
		end
	end

	// Pass and fail flags stay until the next start so software can read them late; done pulses for one cycle
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			res <= '0;
		end else begin
			res.done <= (state == S_DONE) && tz;
			if (state == S_IDLE && start) begin
				res.pass <= 1'b0;
				res.fail_prog <= 1'b0;
				res.fail_low <= 1'b0;
			end else if (read_end && final_pass) begin
				res.pass <= word_ok;
				res.fail_low <= !word_ok;
			end else if (read_end && !bit_ok && last_try) begin
				res.fail_prog <= 1'b1;
			end
		end
	end

	// Helper counters for the checks below
	logic [TMR_W-1:0] since_vcc;
	logic [TMR_W-1:0] pulse_cnt;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			since_vcc <= '0;
			pulse_cnt <= '0;
		end else begin
			since_vcc <= (pins.vcc != next_pins.vcc) ? '0 :
				((&since_vcc) ? since_vcc : since_vcc + 1'b1);
			pulse_cnt <= (|pins.q_oe) ? pulse_cnt + 1'b1 : '0;
		end
	end

	fwe_idle_low_a: assert property (@(posedge clk) disable iff (rst)
		!busy |-> !pins.fwe_logic && !pins.fwe_hv)
		else $error("fuse-write enable high outside a job");
	fwe_two_stage_a: assert property (@(posedge clk) disable iff (rst)
		$rose(pins.fwe_hv) |-> $past(pins.fwe_logic) && pins.fwe_logic)
		else $error("fuse-write enable jumped to program level");
	prog_after_fwe_a: assert property (@(posedge clk) disable iff (rst)
		$rose(pins.vcc == VCC_PROG) |-> $past(pins.fwe_logic, 1) && !pins.fwe_hv)
		else $error("supply raised before fuse-write enable");
	latch_first_a: assert property (@(posedge clk) disable iff (rst)
		$rose(pins.fwe_logic) |-> !pins.chip_en_n && !pins.oe_third && $past(!pins.chip_en_n))
		else $error("fuse-write enable raised before latch or with outputs on");
	one_bit_low_a: assert property (@(posedge clk) disable iff (rst)
		$onehot0(pins.q_oe) && (!(|pins.q_oe) || (pins.fwe_hv && pins.vcc == VCC_PROG)))
		else $error("pulse on several pins or outside program level");
	pull_low_only_a: assert property (@(posedge clk) disable iff (rst)
		pins.q_out == '0)
		else $error("data pin driven high");
	pulse_width_a: assert property (@(posedge clk) disable iff (rst)
		$fell(|pins.q_oe) |-> pulse_cnt == TMR_W'(PULSE_CYC_P) && pins.vcc == VCC_PROG)
		else $error("programming pulse has wrong length");
	step_down_a: assert property (@(posedge clk) disable iff (rst)
		$fell(pins.vcc == VCC_PROG) |-> pins.vcc == VCC_HIGH && !pins.fwe_hv && pins.q_oe == '0)
		else $error("step-down with pulse or high enable still on");
	supply_settle_a: assert property (@(posedge clk) disable iff (rst)
		(pins.vcc != next_pins.vcc && pins.vcc != VCC_OFF) |-> since_vcc >= TMR_W'(SETTLE_CYC_P - 1))
		else $error("supply changed before settling");
	ground_idle_a: assert property (@(posedge clk) disable iff (rst)
		pins.vcc == VCC_OFF |-> pins.addr_in == '0 && !pins.chip_en_n && !pins.oe_third
			&& pins.oe_others == 2'h0 && !pins.fwe_logic)
		else $error("pin high while the part is unpowered");
	verify_latch_a: assert property (@(posedge clk) disable iff (rst)
		$rose(pins.oe_third) |-> !pins.chip_en_n && pins.oe_others == 2'h3 && !pins.fwe_logic)
		else $error("read without latch or with other enables off");
	hold_stable_a: assert property (@(posedge clk) disable iff (rst)
		pins.fwe_logic |-> $stable(pins.addr_in) && !pins.chip_en_n)
		else $error("address or strobe moved during programming");
	low_verify_a: assert property (@(posedge clk) disable iff (rst)
		$rose(pins.vcc == VCC_LOW) |-> pending == '0)
		else $error("low verify entered with bits still pending");
	try_limit_a: assert property (@(posedge clk) disable iff (rst)
		$rose(res.fail_prog) |-> $past(tries) == 3'(MAX_TRIES - 1))
		else $error("bit rejected after wrong number of attempts");

	job_pass_c: cover property (@(posedge clk) disable iff (rst) res.done && res.pass);
	job_fail_prog_c: cover property (@(posedge clk) disable iff (rst) res.done && res.fail_prog);
	job_fail_low_c: cover property (@(posedge clk) disable iff (rst) res.done && res.fail_low);
	retry_c: cover property (@(posedge clk) disable iff (rst) $rose(pins.fwe_hv) && tries != 3'h0);

endmodule : fpr_prog_ctrl

`default_nettype wire

/* File: sim/fpr_prom_model.sv */
// Behavioural fuse PROM that sits in the programmer socket
`timescale 1ns/1ps
`default_nettype none

module fpr_prom_model (
	// Socket pins from the programmer
	input wire fpr_pkg::fpr_pins_t pins,
	// Fault knobs: ignored pulses per bit, bits that never blow, bits weak at low supply
	input wire logic [2:0] extra,
	input wire logic [fpr_pkg::DATA_W-1:0] dead,
	input wire logic [fpr_pkg::DATA_W-1:0] weak_low,
	// Data pin level with pull-ups
	output logic [fpr_pkg::DATA_W-1:0] q_wire
);
	import fpr_pkg::*;

	logic [DATA_W-1:0] mem [WORDS];
	logic [ADDR_W-1:0] lat_addr;
	logic [DATA_W-1:0] q_lat;
	int miss [DATA_W];
	int pb;
	wire q_drive = pins.oe_third && pins.oe_others == 2'h3 && !pins.fwe_logic;
	wire fuse_on = pins.fwe_hv && pins.vcc == VCC_PROG;

	initial begin
		lat_addr = '0;
		q_lat = '0;
		foreach (miss[i]) miss[i] = 0;
		for (int i = 0; i < WORDS; i++) mem[i] = '0;
	end

	// Address and output data both caught on the strobe fall
	always @(negedge pins.chip_en_n) begin
		lat_addr = pins.addr_in;
		q_lat = mem[pins.addr_in] & ~((pins.vcc == VCC_LOW) ? weak_low : 8'h00);
	end

	// Fuse blows at pulse start; a weak fuse swallows a few pulses first
	always @(pins.q_oe) begin
		if (fuse_on && $onehot(pins.q_oe)) begin
			for (pb = 0; pb < DATA_W && !pins.q_oe[pb]; pb++) ;
			if (dead[pb]) begin
			end else if (miss[pb] < int'(extra)) begin
				miss[pb]++;
			end else begin
				mem[lat_addr][pb] = 1'b1;
			end
		end
	end

	always @(pins.vcc) begin
		if (pins.vcc == VCC_OFF) foreach (miss[i]) miss[i] = 0;
	end

	// Released lines float high through the pull-ups
	assign q_wire = (q_drive ? q_lat : 8'hff) & ~pins.q_oe;
endmodule : fpr_prom_model

`default_nettype wire

/* File: sim/fpr_prog_ctrl_tb.sv */
// Self-checking bench for the fuse PROM programmer
`timescale 1ns/1ps
`default_nettype none

module fpr_prog_ctrl_tb;
	import fpr_pkg::*;
	localparam int P = 10;
	localparam int S = 10;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic start = 1'b0;
	logic [ADDR_W-1:0] req_addr = '0;
	logic [DATA_W-1:0] req_data = '0;
	logic [2:0] extra = 3'h0;
	logic [DATA_W-1:0] dead = '0;
	logic [DATA_W-1:0] weak_low = '0;
	logic busy;
	fpr_result_t res;
	logic [DATA_W-1:0] q_in;
	fpr_pins_t pins;
	fpr_pins_t prev = '0;
	int err_total = 0;
	int check_count = 0;
	int pcnt [DATA_W];
	int run = 0;
	int since_vcc = 0;
	int last_bit = 0;
	int tnum = 0;
	int pb;

	always #12.5 clk = ~clk;

	fpr_prog_ctrl #(.PULSE_CYC_P(P), .SETTLE_CYC_P(S)) u_fpr_prog_ctrl (.clk(clk), .rst(rst),
		.start(start), .req_addr(req_addr), .req_data(req_data), .busy(busy), .res(res),
		.q_in(q_in), .pins(pins));
	fpr_prom_model u_fpr_prom_model (.pins(pins), .extra(extra), .dead(dead),
		.weak_low(weak_low), .q_wire(q_in));

	task automatic stop_test();
		$display("checks %0d mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : stop_test

	task automatic chk_v(input logic [31:0] got, input logic [31:0] exp, input string m);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %0h exp %0h", $time, m, got, exp);
		end
	endtask : chk_v

	task automatic chk_f(input logic ok, input string m);
		check_count++;
		if (ok !== 1'b1) begin
			err_total++;
			$display("mismatch at %0t: pin rule %s", $time, m);
		end
	endtask : chk_f

	function automatic int bit_of(input logic [7:0] v);
		for (int i = 0; i < 8; i++) if (v[i]) return i;
		return 8;
	endfunction : bit_of

	// Pin watcher, sampled mid-cycle when registered outputs have settled
	always @(negedge clk) begin
		if (!rst) begin
			chk_f(pins.q_out === 8'h00, "drive high");
			chk_f($countones(pins.q_oe) <= 1, "two pulls");
			if (pins.vcc != VCC_PROG) chk_f(pins.q_oe === 8'h00 && !pins.fwe_hv, "pull off");
			if (pins.vcc == VCC_OFF) chk_f(pins[30:0] === 31'h0, "pin before supply");
			if (pins.fwe_hv) chk_f(pins.fwe_logic === 1'b1, "one-step enable");
			if (pins.fwe_logic) chk_f(busy && pins.chip_en_n === 1'b0 && !pins.oe_third
				&& pins.oe_others === 2'h3 && pins.addr_in === req_addr, "setup");
			if (pins.oe_third) chk_f(pins.oe_others === 2'h3 && !pins.fwe_logic
				&& pins.chip_en_n === 1'b0, "read");
			if (prev.chip_en_n && !pins.chip_en_n) chk_v(pins.addr_in, req_addr, "latch");
			if (!prev.fwe_hv && pins.fwe_hv) chk_f(since_vcc >= S && prev.fwe_logic, "hv");
			if (prev.vcc !== pins.vcc) begin
				if (prev.vcc != VCC_OFF) chk_f(since_vcc >= S, "supply step");
				// Counts the cycles the new level has stood, this one included
				since_vcc = 1;
			end else begin
				since_vcc++;
			end
			if (pins.q_oe != 8'h00) run++;
			if (prev.q_oe != 8'h00 && pins.q_oe == 8'h00) begin
				chk_v(run, P, "pulse length");
				run = 0;
			end
			if (prev.q_oe == 8'h00 && pins.q_oe != 8'h00) begin
				pb = bit_of(pins.q_oe);
				chk_v(req_data[pb], 1'b1, "pulsed bit");
				chk_f(pb >= last_bit, "bit order");
				pcnt[pb]++;
				last_bit = pb;
			end
		end
		prev = pins;
	end

	task automatic job(input logic [8:0] a, input logic [7:0] d, input logic [2:0] x,
			input logic [7:0] dd, input logic [7:0] wl);
		logic [7:0] old;
		logic [7:0] word;
		logic [2:0] flags;
		int f;
		int n;
		old = u_fpr_prom_model.mem[a];
		f = bit_of(d & dd & ~old);
		word = (f < 8) ? old | (d & ~dd & ((8'h01 << f) - 8'h01)) : old | d;
		flags = (f < 8) ? 3'h2 : (((word & ~wl) === d) ? 3'h4 : 3'h1);
		@(posedge clk);
		#2;
		req_addr = a;
		req_data = d;
		extra = x;
		dead = dd;
		weak_low = wl;
		foreach (pcnt[i]) pcnt[i] = 0;
		last_bit = 0;
		start = 1'b1;
		@(posedge clk);
		#2;
		start = 1'b0;
		for (n = 0; n < 70000 && res.done !== 1'b1; n++) @(negedge clk);
		if (n == 70000) begin
			err_total++;
			$display("mismatch at %0t: job timeout", $time);
			stop_test();
		end
		chk_v(busy, 1'b1, "busy at done");
		chk_v({res.pass, res.fail_prog, res.fail_low}, flags, "result");
		chk_v(u_fpr_prom_model.mem[a], word, "fuse word");
		for (int b = 0; b < 8; b++) chk_v(pcnt[b], (!d[b] || b > f) ? 0 : (b == f) ? 8
			: old[b] ? 1 : x + 1, "pulses");
		for (n = 0; n < 4 && busy !== 1'b0; n++) @(negedge clk);
		chk_v(busy, 1'b0, "busy after done");
		tnum++;
		$display("test %0d ended", tnum);
	endtask : job

	initial begin
		void'($urandom(32'h4707));
		repeat (6) @(posedge clk);
		#2;
		rst = 1'b0;
		job(9'h000, 8'h00, 3'h0, 8'h00, 8'h00);
		job(9'h1ff, 8'h81, 3'h0, 8'h00, 8'h00);
		job(9'h1ff, 8'h01, 3'h0, 8'h00, 8'h00);
		job(9'h012, 8'h10, 3'h7, 8'h00, 8'h00);
		job(9'h013, 8'h24, 3'h0, 8'h20, 8'h00);
		job(9'h014, 8'h0f, 3'h1, 8'h00, 8'h02);
		// Random words at random places, some weak fuses among them
		// Sparse words and at most one swallowed pulse keep the run short
		repeat (6) job(9'($urandom), 8'($urandom & $urandom), 3'($urandom % 2), 8'h00, 8'h00);
		stop_test();
	end
endmodule : fpr_prog_ctrl_tb

`default_nettype wire
